// *** src/instruction_format_decoder.sv ***
// Notes on behaviour
// RULE1: Every instruction is one 12-bit word: opcode plus operand fields.
// RULE2: File operand addresses the data register space 0x00 to 0x7F.
// RULE3: Destination bit 0 sends result to accumulator, 1 to the file.
// RULE4: Byte ops: opcode bits 11-6, destination bit 5, file bits 4-0.
// RULE5: Bit ops: opcode bits 11-8, bit index bits 7-5, file bits 4-0.
// RULE6: Bit index selects one bit of the addressed 8-bit register.
// RULE7: Literal and control ops: opcode bits 11-8, literal bits 7-0.
// RULE8: Unconditional jump: opcode bits 11-9, target bits 8-0.
// RULE9: One cycle per instruction; two on true test or pointer change.
// RULE10: One instruction cycle equals four oscillator periods.
// RULE11: Address bits above the 5-bit field come from bank select.
module instruction_format_decoder (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Instruction and context
  input wire logic [11:0] instr_word,
  input wire logic [1:0] bank_select,
  input wire logic cond_true,
  // Sequencing
  output logic [1:0] phase,
  output logic fetch_q,
  output logic exec_valid_q,
  output logic second_cycle_q,
  // Decoded fields
  output decode_pkg::op_class_e class_q,
  output logic [5:0] opcode_q,
  output logic dest_file_q,
  output logic dest_acc_q,
  output logic [6:0] file_addr_q,
  output logic [2:0] bit_index_q,
  output logic [7:0] bit_mask_q,
  output logic [7:0] literal_q,
  output logic [8:0] jump_target_q,
  output logic skip_op_q,
  output logic pc_change_q
);
  phase_if ph ();
  decode_pkg::seq_state_e state_q;
  decode_pkg::op_class_e class_d;
  logic [5:0] opcode_d;
  logic [7:0] mask_d;
  logic skip_d;
  logic pc_change_d;
  logic redirect;
  logic take_now;

  cycle_sequencer u_seq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .ph(ph.seq)
  );

  assign phase = ph.phase;

  // One decoded bit per position of the 8-bit file register
  for (genvar i = 0; i < decode_pkg::MASK_W; i++) begin : g_mask
    assign mask_d[i] = (instr_word[decode_pkg::BIT_HI:decode_pkg::BIT_LO] == 3'(i)); // [RULE6]
  end

  always_comb begin
    class_d = decode_pkg::class_of(instr_word); // [RULE1]
    opcode_d = 6'h00;
    skip_d = 1'b0;
    pc_change_d = 1'b0;
    case (class_d)
      decode_pkg::class_byte: begin
        opcode_d = instr_word[decode_pkg::BYTE_OPC_HI:decode_pkg::BYTE_OPC_LO]; // [RULE4]
        skip_d = (opcode_d == decode_pkg::OPC_DEC_SKIP) || (opcode_d == decode_pkg::OPC_INC_SKIP);
        // Writing the pointer low byte redirects the flow like a jump
        pc_change_d = (instr_word[decode_pkg::DEST_POS] == decode_pkg::DEST_FILE) &&
                      (instr_word[decode_pkg::FILE_HI:decode_pkg::FILE_LO] ==
                       decode_pkg::PTR_LOW_FILE);
      end
      decode_pkg::class_bit: begin
        opcode_d = {2'h0, instr_word[11:decode_pkg::BIT_OPC_LO]}; // [RULE5]
        skip_d = (opcode_d[3:0] == decode_pkg::OPC_BIT_SKIP_CLR) ||
                 (opcode_d[3:0] == decode_pkg::OPC_BIT_SKIP_SET);
      end
      decode_pkg::class_literal: begin
        opcode_d = {2'h0, instr_word[11:decode_pkg::LIT_OPC_LO]}; // [RULE7]
        pc_change_d = (opcode_d[3:0] == decode_pkg::OPC_CALL) ||
                      (opcode_d[3:0] == decode_pkg::OPC_RET_LIT);
      end
      decode_pkg::class_jump: begin
        opcode_d = {3'h0, instr_word[11:decode_pkg::JMP_OPC_LO]}; // [RULE8]
        pc_change_d = 1'b1;
      end
      default: begin
        opcode_d = 6'h00;
      end
    endcase
  end

  // Prefetched word is discarded when the running one redirects [RULE9]
  assign redirect = (state_q == decode_pkg::seq_exec) && exec_valid_q &&
                    (pc_change_q || (skip_op_q && cond_true));
  assign take_now = ph.cycle_end && !redirect;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= decode_pkg::seq_exec;
      second_cycle_q <= 1'b0;
    end else if (ph.cycle_end) begin
      state_q <= redirect ? decode_pkg::seq_flush : decode_pkg::seq_exec; // [RULE9]
      second_cycle_q <= redirect;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fetch_q <= 1'b0;
      exec_valid_q <= 1'b0;
    end else begin
      fetch_q <= take_now;
      if (ph.cycle_end) begin
        exec_valid_q <= take_now;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      class_q <= decode_pkg::class_byte;
      opcode_q <= 6'h00;
      dest_file_q <= 1'b0;
      dest_acc_q <= 1'b0;
      file_addr_q <= decode_pkg::ADDR_MIN;
      bit_index_q <= 3'h0;
      bit_mask_q <= 8'h00;
      literal_q <= 8'h00;
      jump_target_q <= 9'h000;
      skip_op_q <= 1'b0;
      pc_change_q <= 1'b0;
    end else if (take_now) begin
      class_q <= class_d;
      opcode_q <= opcode_d;
      // Destination meaningful for byte ops only [RULE3]
      dest_file_q <= (class_d == decode_pkg::class_byte) &&
                     (instr_word[decode_pkg::DEST_POS] == decode_pkg::DEST_FILE);
      dest_acc_q <= (class_d == decode_pkg::class_byte) &&
                    (instr_word[decode_pkg::DEST_POS] == decode_pkg::DEST_ACC);
      // Bank bits extend the 5-bit field to the full space [RULE2] [RULE11]
      file_addr_q <= {bank_select, instr_word[decode_pkg::FILE_HI:decode_pkg::FILE_LO]};
      bit_index_q <= instr_word[decode_pkg::BIT_HI:decode_pkg::BIT_LO]; // [RULE5]
      bit_mask_q <= mask_d; // [RULE6]
      literal_q <= instr_word[decode_pkg::LIT_HI:0]; // [RULE7]
      jump_target_q <= instr_word[decode_pkg::JMP_HI:0]; // [RULE8]
      skip_op_q <= skip_d;
      pc_change_q <= pc_change_d;
    end
  end

  // Helper copies of the inputs for the checks below
  logic [11:0] last_word_q;
  logic [1:0] last_bank_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      last_word_q <= decode_pkg::WORD_RST;
      last_bank_q <= 2'h0;
    end else begin
      last_word_q <= instr_word;
      last_bank_q <= bank_select;
    end
  end

  chk_class_from_word: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
    fetch_q |-> class_q == decode_pkg::class_of(last_word_q))
    else $error("class does not match fetched word");
  chk_file_addr_bank: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
    fetch_q |-> file_addr_q == {last_bank_q, last_word_q[4:0]} && file_addr_q <= decode_pkg::ADDR_MAX)
    else $error("file address wrong");
  chk_bank_upper: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE11]
    fetch_q |-> file_addr_q[6:5] == last_bank_q)
    else $error("upper address bits not from bank select");
  chk_dest_select: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE3]
    fetch_q && class_q == decode_pkg::class_byte |->
      dest_file_q == last_word_q[5] && dest_acc_q == !last_word_q[5])
    else $error("destination select wrong");
  chk_byte_fields: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE4]
    fetch_q && class_q == decode_pkg::class_byte |-> opcode_q == last_word_q[11:6])
    else $error("byte opcode wrong");
  chk_bit_fields: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE5]
    fetch_q && class_q == decode_pkg::class_bit |->
      opcode_q == {2'h0, last_word_q[11:8]} && bit_index_q == last_word_q[7:5])
    else $error("bit opcode or index wrong");
  chk_bit_mask_onehot: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
    exec_valid_q |-> $onehot(bit_mask_q) && bit_mask_q[bit_index_q])
    else $error("bit mask not one-hot at index");
  chk_literal_fields: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE7]
    fetch_q && class_q == decode_pkg::class_literal |->
      opcode_q == {2'h0, last_word_q[11:8]} && literal_q == last_word_q[7:0])
    else $error("literal fields wrong");
  chk_jump_fields: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE8]
    fetch_q && class_q == decode_pkg::class_jump |->
      opcode_q == {3'h0, last_word_q[11:9]} && jump_target_q == last_word_q[8:0])
    else $error("jump fields wrong");
  chk_two_cycle_redirect: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
    ph.cycle_end && redirect |=> second_cycle_q && !exec_valid_q && !fetch_q [*4] ##1 fetch_q)
    else $error("redirect did not insert one empty cycle");
  chk_one_cycle_plain: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
    ph.cycle_end && !redirect |=> fetch_q && !second_cycle_q)
    else $error("plain instruction not followed by fetch");
  chk_fetch_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE10]
    fetch_q |=> !fetch_q [*3])
    else $error("fetches closer than four periods");
  chk_jump_redirects: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
    fetch_q && class_q == decode_pkg::class_jump |-> pc_change_q && !skip_op_q)
    else $error("jump not marked as pointer change");

  cov_skip_taken: cover property (@(posedge sys_clk) disable iff (!reset_n)
    ph.cycle_end && exec_valid_q && skip_op_q && cond_true);
  cov_jump_flush: cover property (@(posedge sys_clk) disable iff (!reset_n)
    ph.cycle_end && exec_valid_q && class_q == decode_pkg::class_jump);
  cov_byte_to_file: cover property (@(posedge sys_clk) disable iff (!reset_n)
    fetch_q && class_q == decode_pkg::class_byte && dest_file_q);
  cov_bit_op: cover property (@(posedge sys_clk) disable iff (!reset_n)
    fetch_q && class_q == decode_pkg::class_bit && bit_index_q == 3'h7);
  cov_pointer_write: cover property (@(posedge sys_clk) disable iff (!reset_n)
    fetch_q && class_q == decode_pkg::class_byte && pc_change_q);
endmodule // instruction_format_decoder

// *** src/decode_pkg.sv ***
package decode_pkg;
  // Word and field widths
  localparam int WORD_W = 12;
  localparam int OPC_W = 6;
  localparam int FILE_W = 5;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int MASK_W = 8;
  localparam int LIT_W = 8;
  localparam int JMP_W = 9;

  // Field positions
  localparam int BYTE_OPC_HI = 11;
  localparam int BYTE_OPC_LO = 6;
  localparam int DEST_POS = 5;
  localparam int FILE_HI = 4;
  localparam int FILE_LO = 0;
  localparam int BIT_OPC_LO = 8;
  localparam int BIT_HI = 7;
  localparam int BIT_LO = 5;
  localparam int LIT_OPC_LO = 8;
  localparam int LIT_HI = 7;
  localparam int JMP_OPC_LO = 9;
  localparam int JMP_HI = 8;

  // Register file address space
  localparam logic [ADDR_W-1:0] ADDR_MIN = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;
  localparam logic [FILE_W-1:0] PTR_LOW_FILE = 5'h02;

  // Destination select encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Class and opcode codes
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [3:0] OPC_BIT_SKIP_CLR = 4'h6;
  localparam logic [3:0] OPC_BIT_SKIP_SET = 4'h7;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [3:0] OPC_CALL = 4'h9;
  localparam logic [3:0] OPC_RET_LIT = 4'h8;

  // Instruction cycle timing
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;

  typedef enum logic [1:0] {class_byte, class_bit, class_literal, class_jump} op_class_e;
  typedef enum logic {seq_exec, seq_flush} seq_state_e;

  function automatic op_class_e class_of(input logic [WORD_W-1:0] w);
    if (w[11:10] == TOP_BYTE) begin
      class_of = class_byte;
    end else if (w[11:10] == TOP_BIT) begin
      class_of = class_bit;
    end else if (w[11:9] == OPC_JUMP) begin
      class_of = class_jump;
    end else begin
      class_of = class_literal;
    end
  endfunction
endpackage

// *** src/phase_if.sv ***
interface phase_if;
  logic [1:0] phase;
  logic cycle_end;
  modport seq (output phase, output cycle_end);
  modport dec (input phase, input cycle_end);
endinterface

// *** src/cycle_sequencer.sv ***
module cycle_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Phase outputs
  phase_if.seq ph
);
  logic [1:0] phase_q;

  // Four oscillator periods per instruction cycle [RULE10]
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_q <= decode_pkg::PHASE_FIRST;
    end else if (phase_q == decode_pkg::PHASE_LAST) begin
      phase_q <= decode_pkg::PHASE_FIRST;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign ph.phase = phase_q;
  assign ph.cycle_end = (phase_q == decode_pkg::PHASE_LAST);

  chk_cycle_four_periods: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE10]
    ph.cycle_end |=> !ph.cycle_end [*3] ##1 ph.cycle_end)
    else $error("instruction cycle is not four clock periods");
endmodule // cycle_sequencer

// *** bench/tb_instruction_format_decoder.sv ***
module tb_instruction_format_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic reset_n;
  logic [11:0] instr_word;
  logic [1:0] bank_select;
  logic cond_true;
  logic [1:0] phase;
  logic fetch_q, exec_valid_q, second_cycle_q, dest_file_q, dest_acc_q, skip_op_q, pc_change_q;
  decode_pkg::op_class_e class_q;
  logic [5:0] opcode_q;
  logic [6:0] file_addr_q;
  logic [2:0] bit_index_q;
  logic [7:0] bit_mask_q, literal_q;
  logic [8:0] jump_target_q;
  int bad_count, cmp_count;
  logic [31:0] rng;
  logic [46:0] exp_f;
  logic exp_ex, exp_sec, started;
  // Jump, both byte skips, bit skips, call, return, write to pointer file
  logic [11:0] dir_words [8] = '{12'ha05, 12'h2c3, 12'h3e2, 12'h6a4,
                                 12'h7e1, 12'h912, 12'h8ff, 12'h022};

  instruction_format_decoder instruction_format_decoder_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .instr_word(instr_word), .bank_select(bank_select),
    .cond_true(cond_true), .phase(phase), .fetch_q(fetch_q), .exec_valid_q(exec_valid_q),
    .second_cycle_q(second_cycle_q), .class_q(class_q), .opcode_q(opcode_q),
    .dest_file_q(dest_file_q), .dest_acc_q(dest_acc_q), .file_addr_q(file_addr_q),
    .bit_index_q(bit_index_q), .bit_mask_q(bit_mask_q), .literal_q(literal_q),
    .jump_target_q(jump_target_q), .skip_op_q(skip_op_q), .pc_change_q(pc_change_q));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Fields packed in port order, worked out from the word and bank select
  function automatic logic [46:0] model(input logic [11:0] w, input logic [1:0] b);
    logic [1:0] c;
    logic [5:0] o;
    logic sk, pcc;
    c = (w[11:10] == 2'h0) ? 2'h0 : (w[11:10] == 2'h1) ? 2'h1 : (w[11:9] == 3'h5) ? 2'h3 : 2'h2;
    o = (c == 2'h0) ? w[11:6] : (c == 2'h3) ? {3'h0, w[11:9]} : {2'h0, w[11:8]};
    sk = (c == 2'h0 && (o == 6'h0b || o == 6'h0f)) || (c == 2'h1 && (o == 6'h06 || o == 6'h07));
    pcc = c == 2'h3 || (c == 2'h2 && (o == 6'h08 || o == 6'h09))
          || (c == 2'h0 && w[5] && w[4:0] == 5'h02);
    return {c, o, c == 2'h0 && w[5], c == 2'h0 && !w[5], b, w[4:0], w[7:5],
            8'h01 << w[7:5], w[7:0], w[8:0], sk, pcc};
  endfunction

  function automatic logic [46:0] fields();
    return {class_q, opcode_q, dest_file_q, dest_acc_q, file_addr_q, bit_index_q,
            bit_mask_q, literal_q, jump_target_q, skip_op_q, pc_change_q};
  endfunction

  task automatic check(input logic [46:0] got, input logic [46:0] want, input string what);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check({42'h0, fetch_q, exec_valid_q, second_cycle_q, phase}, 47'h0, "reset status");
    check(fields(), 47'h0, "reset fields");
    reset_n = 1'b1;
    exp_f = 47'h0;
    exp_ex = 1'b0;
    exp_sec = 1'b0;
    started = 1'b0;
  endtask

  // Offers one word; repeats it once if the edge is a redirect
  task automatic step(input logic [11:0] w, input logic [1:0] b, input logic c);
    int n;
    logic nr;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (phase !== 2'h3 && n < 8);
      if (started) check(47'(n), 47'd2, "cycle length");
      started = 1'b1;
      check(fields(), exp_f, "held fields");
      check({44'h0, exec_valid_q, second_cycle_q, 1'b0}, {44'h0, exp_ex, exp_sec, 1'b0}, "held");
      instr_word = w;
      bank_select = b;
      cond_true = c;
      nr = exp_ex && (exp_f[0] || (exp_f[1] && c));
      @(negedge sys_clk);
      if (nr) begin
        exp_ex = 1'b0;
        exp_sec = 1'b1;
      end else begin
        exp_f = model(w, b);
        exp_ex = 1'b1;
        exp_sec = 1'b0;
      end
      check({42'h0, fetch_q, exec_valid_q, second_cycle_q, phase},
            {42'h0, !nr, exp_ex, exp_sec, 2'h0}, "take status");
      check(fields(), exp_f, "fields");
      @(negedge sys_clk);
      check({44'h0, fetch_q, phase}, {44'h0, 1'b0, 2'h1}, "pulse end");
      if (!nr) break;
    end
  endtask

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rng = 32'd52624;
    reset_n = 1'b0;
    instr_word = 12'h000;
    bank_select = 2'h0;
    cond_true = 1'b0;
    do_reset();
    for (int i = 0; i < 60; i++) begin
      rng = xorshift(rng);
      step(i < 8 ? dir_words[i] : rng[11:0], rng[13:12], i < 8 ? 1'b1 : rng[20]);
    end
    // Reset in mid-run must restart the phase count cleanly
    do_reset();
    for (int i = 0; i < 30; i++) begin
      rng = xorshift(rng);
      step(rng[11:0], rng[13:12], rng[20]);
    end
    results();
  end

  initial begin
    #100us;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule // tb_instruction_format_decoder
